// File: common/ftr_regs.svh
`ifndef FTR_REGS_SVH
`define FTR_REGS_SVH

// ****************************************
// Register map
// ****************************************
`define FTR_ADDR_W 8
`define FTR_ADDR_LIMITS 8'h3c
`define FTR_ADDR_QDATA 8'h3d
`define FTR_WORD_W 24
`define FTR_LIMITS_RST 24'hff_f000
`define FTR_QDATA_RST 16'h0000

// ****************************************
// Field positions
// ****************************************
`define FTR_UP_MSB 23
`define FTR_UP_LSB 12
`define FTR_LO_MSB 11
`define FTR_LO_LSB 0
`define FTR_LIM_W 12
`define FTR_SMP_W 16
`define FTR_SMP_MSB 15
`define FTR_SMP_LSB 4

// ****************************************
// Queue and channel sizes
// ****************************************
`define FTR_QDEPTH 16
`define FTR_CNT_W 5
`define FTR_CHAN_W 4
`define FTR_NCHAN 16

`endif

// File: common/ftr_pkg.sv
`include "ftr_regs.svh"

package ftr_pkg;
  typedef logic [`FTR_ADDR_W-1:0] ftr_addr_t;
  typedef logic [`FTR_WORD_W-1:0] ftr_word_t;
  typedef logic [`FTR_SMP_W-1:0] ftr_sample_t;
  typedef logic [`FTR_LIM_W-1:0] ftr_limit_t;
  typedef logic [`FTR_CNT_W-1:0] ftr_count_t;
  typedef logic [`FTR_CHAN_W-1:0] ftr_chan_t;
  typedef logic [`FTR_NCHAN-1:0] ftr_chanmask_t;

  // Upper limit field of the limits word
  function automatic ftr_limit_t ftr_upper_of(input ftr_word_t w);
    return w[`FTR_UP_MSB:`FTR_UP_LSB];
  endfunction

  // Lower limit field of the limits word
  function automatic ftr_limit_t ftr_lower_of(input ftr_word_t w);
    return w[`FTR_LO_MSB:`FTR_LO_LSB];
  endfunction
endpackage

// File: common/ftr_q_if.sv
`timescale 1ns/1ps

// Queue handshake between the control logic and the sample store
interface ftr_q_if #(parameter int WIDTH = 16, parameter int CW = 5) ();
  logic in_valid;
  logic in_ready;
  logic [WIDTH-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [WIDTH-1:0] out_data;
  logic [CW-1:0] count;
  logic flush;

  modport fifo_mp (
    input in_valid, in_data, out_ready, flush,
    output in_ready, out_valid, out_data, count
  );
  modport user_mp (
    output in_valid, in_data, out_ready, flush,
    input in_ready, out_valid, out_data, count
  );
endinterface

// File: hw/ftr_fifo.sv
`timescale 1ns/1ps

module ftr_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,  // System clock
  input wire logic rst_i,  // Sync reset, active high
  ftr_q_if.fifo_mp q       // Queue handshake
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic ready_r, ready_nxt, valid_r, valid_nxt;
  logic push, pop;

  // Pointer step with wrap
  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // Handshake flags come from flops
  assign q.in_ready = ready_r;
  assign q.out_valid = valid_r;
  assign q.out_data = mem_r[rd_r];
  assign q.count = cnt_r;

  // Next pointers, count and storage
  always_comb
  begin
    push = q.in_valid && ready_r;
    pop = q.out_ready && valid_r;
    mem_nxt = mem_r;
    wr_nxt = wr_r;
    rd_nxt = rd_r;
    cnt_nxt = cnt_r;
    if (q.flush)
    begin
      wr_nxt = '0;
      rd_nxt = '0;
      cnt_nxt = '0;
    end
    else
    begin
      if (push)
      begin
        mem_nxt[wr_r] = q.in_data;
        wr_nxt = ptr_inc(wr_r);
      end
      if (pop)
        rd_nxt = ptr_inc(rd_r);
      if (push && !pop)
        cnt_nxt = cnt_r + 1'b1;
      else if (pop && !push)
        cnt_nxt = cnt_r - 1'b1;
    end
    ready_nxt = (cnt_nxt != CW'(DEPTH));
    valid_nxt = (cnt_nxt != '0);
  end

  // State registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      foreach (mem_r[i])
        mem_r[i] <= '0;
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
      ready_r <= 1'b1;
      valid_r <= 1'b0;
    end
    else
    begin
      mem_r <= mem_nxt;
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
      ready_r <= ready_nxt;
      valid_r <= valid_nxt;
    end
  end
endmodule // ftr_fifo

// File: hw/ftr_limit_cmp.sv
`timescale 1ns/1ps

module ftr_limit_cmp (
  input wire ftr_pkg::ftr_limit_t sample_i,  // Compared part of the result
  input wire ftr_pkg::ftr_limit_t upper_i,   // Upper limit
  input wire ftr_pkg::ftr_limit_t lower_i,   // Lower limit
  input wire logic check_on_i,               // Channel check enabled
  output logic at_upper_o,                   // At or above upper limit
  output logic at_lower_o                    // At or below lower limit
);
  import ftr_pkg::*;

  // Inclusive comparisons, gated by channel enable
  always_comb
  begin
    at_upper_o = check_on_i && (sample_i >= upper_i);
    at_lower_o = check_on_i && (sample_i <= lower_i);
  end
endmodule // ftr_limit_cmp

// File: hw/ftr_top.sv
`timescale 1ns/1ps
`include "ftr_regs.svh"

module ftr_top (
  input wire logic clk_i,                                  // 200 MHz clock
  input wire logic rst_i,                                  // Sync reset, high
  input wire logic reg_wr_i,                               // Register write
  input wire logic reg_rd_i,                               // Register read
  input wire ftr_pkg::ftr_addr_t reg_addr_i,               // Register address
  input wire ftr_pkg::ftr_word_t reg_wdata_i,              // Write data
  output ftr_pkg::ftr_word_t reg_rdata_o,                  // Read data
  output logic reg_rvalid_o,                               // Read answer
  input wire logic conv_valid_i,                           // Result offered
  input wire ftr_pkg::ftr_sample_t conv_data_i,            // Conversion result
  input wire ftr_pkg::ftr_chan_t conv_chan_i,              // Result channel
  input wire ftr_pkg::ftr_chanmask_t channel_limit_check_on_i, // Per channel
  output logic conv_ready_o,                               // Queue has room
  input wire logic fifo_en_i,                              // Queue enabled
  input wire logic fifo_clear_i,                           // Flush pulse
  input wire ftr_pkg::ftr_count_t watermark_i,             // Watermark level
  input wire logic status_clr_i,                           // Clear limit flags
  output logic upper_limit_hit_o,                          // Upper flag
  output logic lower_limit_hit_o,                          // Lower flag
  output logic empty_flag_o,                               // Queue empty
  output logic watermark_flag_o,                           // Watermark flag
  output logic watermark_irq_o                             // Watermark irq
);
  import ftr_pkg::*;

  // ****************************************
  // Queue instance
  // ****************************************
  ftr_q_if #(.WIDTH(`FTR_SMP_W), .CW(`FTR_CNT_W)) q ();

  ftr_fifo #(.WIDTH(`FTR_SMP_W), .DEPTH(`FTR_QDEPTH)) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .q(q.fifo_mp)
  );

  // ****************************************
  // Declarations
  // ****************************************
  ftr_word_t limits_r, limits_nxt;
  logic upper_hit_r, upper_hit_nxt;
  logic lower_hit_r, lower_hit_nxt;
  logic empty_r, empty_nxt;
  logic wm_r, wm_nxt;
  logic wm_irq_r, wm_irq_nxt;
  ftr_word_t rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic data_rd, push, chk_on, at_upper, at_lower;
  ftr_limit_t sample_part;

  // Address match for register access
  function automatic logic addr_is(input ftr_addr_t a, input ftr_addr_t t);
    return a == t;
  endfunction

  // ****************************************
  // Queue feed and drain
  // ****************************************
  // Samples enter only while the queue is enabled
  assign q.in_valid = conv_valid_i && fifo_en_i;
  assign q.in_data = conv_data_i;
  assign q.flush = fifo_clear_i || !fifo_en_i;
  assign q.out_ready = data_rd;
  assign conv_ready_o = q.in_ready;
  assign data_rd = reg_rd_i && addr_is(reg_addr_i, `FTR_ADDR_QDATA);
  assign push = q.in_valid && q.in_ready && !q.flush;

  // ****************************************
  // Limit comparison
  // ****************************************
  assign sample_part = conv_data_i[`FTR_SMP_MSB:`FTR_SMP_LSB];
  assign chk_on = channel_limit_check_on_i[conv_chan_i];

  ftr_limit_cmp u_cmp (
    .sample_i(sample_part),
    .upper_i(ftr_upper_of(limits_r)),
    .lower_i(ftr_lower_of(limits_r)),
    .check_on_i(chk_on),
    .at_upper_o(at_upper),
    .at_lower_o(at_lower)
  );

  // ****************************************
  // Limits register
  // ****************************************
  // Next limits value
  always_comb
  begin
    limits_nxt = limits_r;
    if (reg_wr_i && addr_is(reg_addr_i, `FTR_ADDR_LIMITS))
      limits_nxt = reg_wdata_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      limits_r <= `FTR_LIMITS_RST;
    else
      limits_r <= limits_nxt;
  end

  // ****************************************
  // Status flags
  // ****************************************
  // Next flag values, set wins over clear
  always_comb
  begin
    upper_hit_nxt = upper_hit_r;
    lower_hit_nxt = lower_hit_r;
    if (status_clr_i || q.flush)
    begin
      upper_hit_nxt = 1'b0;
      lower_hit_nxt = 1'b0;
    end
    if (push && at_upper)
      upper_hit_nxt = 1'b1;
    if (push && at_lower)
      lower_hit_nxt = 1'b1;
    empty_nxt = !fifo_en_i || !q.out_valid;
    wm_nxt = fifo_en_i && (q.count >= watermark_i);
    wm_irq_nxt = wm_nxt;
  end

  // Flag registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      upper_hit_r <= 1'b0;
      lower_hit_r <= 1'b0;
      empty_r <= 1'b1;
      wm_r <= 1'b0;
      wm_irq_r <= 1'b0;
    end
    else
    begin
      upper_hit_r <= upper_hit_nxt;
      lower_hit_r <= lower_hit_nxt;
      empty_r <= empty_nxt;
      wm_r <= wm_nxt;
      wm_irq_r <= wm_irq_nxt;
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  // Next read answer
  always_comb
  begin
    rvalid_nxt = reg_rd_i;
    rdata_nxt = '0;
    if (reg_rd_i)
    begin
      if (addr_is(reg_addr_i, `FTR_ADDR_LIMITS))
        rdata_nxt = limits_r;
      else if (data_rd && q.out_valid)
        rdata_nxt = {{(`FTR_WORD_W - `FTR_SMP_W){1'b0}}, q.out_data};
      else if (data_rd)
        rdata_nxt = {{(`FTR_WORD_W - `FTR_SMP_W){1'b0}}, `FTR_QDATA_RST};
    end
  end

  // Read registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rdata_r <= '0;
      rvalid_r <= 1'b0;
    end
    else
    begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // Outputs straight from flops
  assign reg_rdata_o = rdata_r;
  assign reg_rvalid_o = rvalid_r;
  assign upper_limit_hit_o = upper_hit_r;
  assign lower_limit_hit_o = lower_hit_r;
  assign empty_flag_o = empty_r;
  assign watermark_flag_o = wm_r;
  assign watermark_irq_o = wm_irq_r;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Data address read with a stored sample
  sequence s_read_full;
    data_rd && q.out_valid;
  endsequence

  // Data address read with nothing stored
  sequence s_read_empty;
    data_rd && !q.out_valid;
  endsequence

  // Stored sample at or above upper limit
  sequence s_push_upper;
    push && chk_on && (sample_part >= ftr_upper_of(limits_r));
  endsequence

  // Stored sample at or below lower limit
  sequence s_push_lower;
    push && chk_on && (sample_part <= ftr_lower_of(limits_r));
  endsequence

  // Sample taken, queue still enabled next cycle
  sequence s_push_stay_on;
    push ##1 fifo_en_i;
  endsequence

  a_upper_flag_set: assert property (s_push_upper |=> upper_limit_hit_o)
    else $error("upper flag not set");

  a_lower_flag_set: assert property (s_push_lower |=> lower_limit_hit_o)
    else $error("lower flag not set");

  a_limits_reset_val: assert property ($fell(rst_i) |-> limits_r == `FTR_LIMITS_RST)
    else $error("limits reset value wrong");

  a_data_read_answer: assert property (
    s_read_full |=> reg_rvalid_o && reg_rdata_o == $past(q.out_data))
    else $error("data read answer wrong");

  a_empty_read_zero: assert property (s_read_empty |=> reg_rvalid_o ##0 reg_rdata_o == '0)
    else $error("empty read not zero");

  a_empty_when_off: assert property (!fifo_en_i |=> empty_flag_o ##1 empty_flag_o)
    else $error("empty flag low while disabled");

  a_wm_flag_level: assert property (
    fifo_en_i && q.count >= watermark_i |=> watermark_flag_o && watermark_irq_o)
    else $error("watermark flag wrong");

  a_wm_irq_follow: assert property (watermark_irq_o == watermark_flag_o)
    else $error("watermark irq differs from flag");

  a_read_pops_one: assert property (
    s_read_full and (!push && !q.flush) |=> q.count == $past(q.count) - 1'b1)
    else $error("read did not pop one entry");

  a_empty_read_keeps: assert property (
    s_read_empty and (!push && !q.flush) |=> q.count == $past(q.count))
    else $error("empty read changed the count");

  a_rvalid_follows_rd: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read answer missing");

  a_rvalid_only_rd: assert property (!reg_rd_i |=> !reg_rvalid_o && reg_rdata_o == '0)
    else $error("read answer without read");

  a_unmapped_zero: assert property (
    reg_rd_i && !addr_is(reg_addr_i, `FTR_ADDR_LIMITS) && !data_rd |=> reg_rdata_o == '0)
    else $error("unmapped read not zero");

  a_limits_write: assert property (
    reg_wr_i && addr_is(reg_addr_i, `FTR_ADDR_LIMITS) |=> limits_r == $past(reg_wdata_i))
    else $error("limits write lost");

  a_limits_hold: assert property (
    !(reg_wr_i && addr_is(reg_addr_i, `FTR_ADDR_LIMITS)) |=> $stable(limits_r))
    else $error("limits changed without write");

  a_empty_after_push: assert property (s_push_stay_on |=> !empty_flag_o)
    else $error("empty flag high with data stored");

  a_empty_when_none: assert property (!q.out_valid |=> empty_flag_o)
    else $error("empty flag low with queue empty");

  a_wm_flag_low: assert property (
    !(fifo_en_i && q.count >= watermark_i) |=> !watermark_flag_o)
    else $error("watermark flag high below level");

  a_flags_cleared: assert property (
    (status_clr_i || q.flush) && !push |=> !upper_limit_hit_o && !lower_limit_hit_o)
    else $error("limit flags not cleared");

  a_upper_hit_sticky: assert property (
    upper_limit_hit_o && !status_clr_i && !q.flush |=> upper_limit_hit_o)
    else $error("upper flag dropped without clear");

  a_lower_hit_sticky: assert property (
    lower_limit_hit_o && !status_clr_i && !q.flush |=> lower_limit_hit_o)
    else $error("lower flag dropped without clear");
endmodule // ftr_top

// File: verification/ftr_host_model.sv
`timescale 1ns/1ps

// ****************************************
// Host issuing register accesses
// ****************************************
module ftr_host_model (
  input wire logic clk_i,                      // System clock
  output logic reg_wr_o,                       // Write strobe
  output logic reg_rd_o,                       // Read strobe
  output ftr_pkg::ftr_addr_t reg_addr_o,       // Address
  output ftr_pkg::ftr_word_t reg_wdata_o,      // Write data
  input wire ftr_pkg::ftr_word_t reg_rdata_i,  // Read data
  input wire logic reg_rvalid_i                // Read answer
);
  import ftr_pkg::*;

  // Idle bus at start
  initial
  begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 24'h00_0000;
  end

  // One write, released data shows inverse
  task automatic wr(input ftr_addr_t a, input ftr_word_t d);
    reg_wr_o <= 1'b1;
    reg_addr_o <= a;
    reg_wdata_o <= d;
    @(posedge clk_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
    @(posedge clk_i);
  endtask

  // read taken, answer one cycle later
  task automatic rd(input ftr_addr_t a, output ftr_word_t d);
    reg_rd_o <= 1'b1;
    reg_addr_o <= a;
    @(posedge clk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    @(posedge clk_i);
    d = (reg_rvalid_i === 1'b1) ? reg_rdata_i : 'x;
  endtask
endmodule // ftr_host_model

// File: verification/tb.sv
`timescale 1ns/1ps
`include "ftr_regs.svh"

module tb;
  import ftr_pkg::*;
  logic clk_i, rst_i, reg_wr_i, reg_rd_i, reg_rvalid_o, conv_valid_i, conv_ready_o;
  logic fifo_en_i, fifo_clear_i, status_clr_i, up_o, lo_o, empty_o, wm_o, irq_o;
  ftr_addr_t reg_addr_i;
  ftr_word_t reg_wdata_i, reg_rdata_o, d, lim;
  ftr_sample_t conv_data_i, s;
  ftr_chan_t conv_chan_i;
  ftr_chanmask_t mask;
  ftr_count_t watermark_i;
  ftr_sample_t q[$];
  logic exp_up, exp_lo;
  int mismatches, n_compared;
  integer seed = 32'hebbf0b8d;

  ftr_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .conv_valid_i(conv_valid_i), .conv_data_i(conv_data_i),
    .conv_chan_i(conv_chan_i), .channel_limit_check_on_i(mask), .conv_ready_o(conv_ready_o),
    .fifo_en_i(fifo_en_i), .fifo_clear_i(fifo_clear_i), .watermark_i(watermark_i),
    .status_clr_i(status_clr_i), .upper_limit_hit_o(up_o), .lower_limit_hit_o(lo_o),
    .empty_flag_o(empty_o), .watermark_flag_o(wm_o), .watermark_irq_o(irq_o));

  ftr_host_model u_host (.clk_i(clk_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
    .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o),
    .reg_rvalid_i(reg_rvalid_o));

  // Clock, 5 ns period
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // Compare and count
  task automatic check(input string nm, input ftr_word_t seen, input ftr_word_t exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Status outputs against the model
  task automatic chk_state;
    check("upper", up_o, exp_up);
    check("lower", lo_o, exp_lo);
    check("empty", empty_o, q.size() == 0);
    check("wmark", wm_o, q.size() >= watermark_i);
    check("wm_irq", irq_o, q.size() >= watermark_i);
  endtask

  // Offer one result, then let flags settle
  task automatic push(input ftr_chan_t c, input ftr_sample_t v);
    conv_chan_i <= c;
    conv_data_i <= v;
    conv_valid_i <= 1'b1;
    do @(posedge clk_i); while (conv_ready_o !== 1'b1);
    conv_valid_i <= 1'b0;
    if (fifo_en_i)
    begin
      q.push_back(v);
      exp_up |= mask[c] && v[`FTR_SMP_MSB:`FTR_SMP_LSB] >= lim[`FTR_UP_MSB:`FTR_UP_LSB];
      exp_lo |= mask[c] && v[`FTR_SMP_MSB:`FTR_SMP_LSB] <= lim[`FTR_LO_MSB:`FTR_LO_LSB];
    end
    repeat (4) @(posedge clk_i);
  endtask

  // One-cycle pulse on a control input
  task automatic pulse(input bit clr);
    if (clr) fifo_clear_i <= 1'b1;
    else status_clr_i <= 1'b1;
    @(posedge clk_i);
    fifo_clear_i <= 1'b0;
    status_clr_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    exp_up = 1'b0;
    exp_lo = 1'b0;
    if (clr) q.delete();
  endtask

  // Hang guard
  initial
  begin
    repeat (5000) @(posedge clk_i);
    mismatches++;
    tally_and_finish();
  end

  // Main sequence
  initial
  begin
    {rst_i, conv_valid_i, fifo_en_i, fifo_clear_i, status_clr_i} = 5'b1_0100;
    {conv_data_i, conv_chan_i, mask, exp_up, exp_lo} = '0;
    lim = `FTR_LIMITS_RST;
    watermark_i = 5'h04;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk_state();
    u_host.rd(`FTR_ADDR_LIMITS, d);
    check("limits_rst", d, `FTR_LIMITS_RST);
    u_host.rd(`FTR_ADDR_QDATA, d);
    check("qdata_rst", d, 24'h00_0000);
    u_host.rd(8'h5a, d);
    check("unmapped", d, 24'h00_0000);
    lim = 24'h80_0100;
    u_host.wr(`FTR_ADDR_LIMITS, lim);
    u_host.rd(`FTR_ADDR_LIMITS, d);
    check("limits_rw", d, lim);
    // Write to the read-only data port is ignored
    u_host.wr(`FTR_ADDR_QDATA, 24'h12_3456);
    u_host.rd(`FTR_ADDR_LIMITS, d);
    check("limits_ro", d, lim);
    u_host.rd(`FTR_ADDR_QDATA, d);
    check("qdata_ro", d, 24'h00_0000);
    pulse(1'b1);
    mask <= (ftr_chanmask_t'($random(seed)) | 16'h0001) & 16'hfffd;
    watermark_i <= ftr_count_t'(($random(seed) & 15) + 1);
    // Boundary cases, then random results, until the queue is full
    for (int i = 0; i < `FTR_QDEPTH; i++)
    begin
      case (i)
        0: push(4'h0, 16'h7fff);
        1: push(4'h1, 16'hfff0);
        2: push(4'h1, 16'h0000);
        3: push(4'h0, 16'h1010);
        4: push(4'h0, 16'h800f);
        5: push(4'h0, 16'h1000);
        default: push(ftr_chan_t'($random(seed)), ftr_sample_t'($random(seed)));
      endcase
      chk_state();
    end
    check("full", conv_ready_o, 1'b0);
    // Drain in arrival order
    while (q.size() > 0)
    begin
      s = q.pop_front();
      u_host.rd(`FTR_ADDR_QDATA, d);
      check("qdata", d, {8'h00, s});
      repeat (3) @(posedge clk_i);
      chk_state();
    end
    u_host.rd(`FTR_ADDR_QDATA, d);
    check("qdata_empty", d, 24'h00_0000);
    pulse(1'b0);
    chk_state();
    // Clear and a matching sample in one cycle: the set wins
    status_clr_i <= 1'b1;
    conv_chan_i <= 4'h0;
    conv_data_i <= 16'hffff;
    conv_valid_i <= 1'b1;
    @(posedge clk_i);
    status_clr_i <= 1'b0;
    conv_valid_i <= 1'b0;
    q.push_back(16'hffff);
    exp_up = 1'b1;
    repeat (4) @(posedge clk_i);
    chk_state();
    pulse(1'b1);
    chk_state();
    fifo_en_i <= 1'b0;
    push(4'h0, 16'h1234);
    chk_state();
    tally_and_finish();
  end
endmodule // tb
